// ==== hdl/ifs_pkg.sv ====
// Constants for the imprecise float and supervisor call entry unit
package ifs_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] IFS_OFS_MACHINE_STATE = 8'h00;
    localparam logic [7:0] IFS_OFS_SAVE_RESTORE_ADDRESS = 8'h04;
    localparam logic [7:0] IFS_OFS_SAVE_RESTORE_STATUS = 8'h08;
    localparam logic [7:0] IFS_OFS_LINK_RETURN = 8'h0C;
    localparam logic [7:0] IFS_OFS_LOOP_COUNT = 8'h10;
    localparam logic [7:0] IFS_OFS_FLOAT_STATUS_CONTROL = 8'h14;
    localparam logic [7:0] IFS_OFS_ENTRY_STATUS = 8'h18;

    // Machine state bits, big-endian bit n sits at index 31-n
    localparam int IFS_MS_EXTERNAL_IRQ_ENABLE = 15;
    localparam int IFS_MS_USER_MODE_FLAG = 14;
    localparam int IFS_MS_FLOAT_AVAILABLE = 13;
    localparam int IFS_MS_MACHINE_CHECK_ENABLE = 12;
    localparam int IFS_MS_FLOAT_EXC_MODE = 11;
    localparam int IFS_MS_SINGLE_STEP_TRACE = 10;
    localparam int IFS_MS_BRANCH_TRACE = 9;
    localparam int IFS_MS_IMPRECISE_ALLOW = 8;
    localparam int IFS_MS_WORD_BOUNDARY_CHECK = 7;
    localparam int IFS_MS_VECTOR_BASE_SELECT = 6;
    localparam int IFS_MS_INSTR_TRANSLATE = 5;
    localparam int IFS_MS_DATA_TRANSLATE = 4;
    localparam int IFS_MS_PERF_MONITOR_MARK = 2;

    // Float status control summary bit (big-endian bit 1)
    localparam int IFS_FSC_FLOAT_EXC_SUMMARY = 30;

    // Supervisor call instruction fields
    localparam int IFS_SC_SAVE_RETURN_FLAG = 0;
    localparam int IFS_SC_ABSOLUTE_VECTOR_SELECT = 1;
    localparam int IFS_SC_ENTRY_INDEX_LSB = 5;
    localparam int IFS_SC_ENTRY_INDEX_W = 7;

    // Resume offsets and instruction size
    localparam logic [31:0] IFS_VEC_IMPRECISE = 32'h00000A00;
    localparam logic [31:0] IFS_VEC_SC_ABSOLUTE = 32'h00001FE0;
    localparam logic [4:0] IFS_VEC_SC_PREFIX = 5'h01;
    localparam logic [4:0] IFS_VEC_SC_SUFFIX = 5'h00;
    localparam logic [31:0] IFS_INSTR_BYTES = 32'h00000004;

    localparam logic [31:0] IFS_RESET_WORD = 32'h00000000;

    typedef enum logic [2:0]
    {
        IFS_KIND_NONE = 3'b001,
        IFS_KIND_IMPRECISE = 3'b010,
        IFS_KIND_SC = 3'b100
    } ifs_kind_e;
endpackage

// ==== hdl/ifs_vec_if.sv ====
// Request and answer between the entry unit and its vector calculator
interface ifs_vec_if;
    logic is_sc;
    logic base_high;
    logic absolute;
    logic [6:0] entry_index;
    logic [31:0] target;
    modport req (output is_sc, output base_high, output absolute, output entry_index,
        input target);
    modport calc (input is_sc, input base_high, input absolute, input entry_index,
        output target);
endinterface

// ==== hdl/ifs_vector.sv ====
// Resume address calculator for both entry kinds
module ifs_vector
    import ifs_pkg::*;
#(
    parameter logic [31:0] BASE_LOW = 32'h00000000,
    parameter logic [31:0] BASE_HIGH = 32'hFFF00000
)
(
    ifs_vec_if.calc v
);
    logic [31:0] base;
    logic [31:0] offset;

    always_comb
    begin
        base = v.base_high ? BASE_HIGH : BASE_LOW;
        if (!v.is_sc)
        begin
            offset = IFS_VEC_IMPRECISE;
        end
        else if (v.absolute)
        begin
            offset = IFS_VEC_SC_ABSOLUTE;
        end
        else
        begin
            offset = {15'h0000, IFS_VEC_SC_PREFIX, v.entry_index, IFS_VEC_SC_SUFFIX};
        end
        v.target = base + offset;
    end
endmodule

// ==== hdl/ifs_entry.sv ====
// Imprecise float and supervisor call interrupt entry with APB registers
module ifs_entry
    import ifs_pkg::*;
#(
    parameter logic [31:0] BASE_LOW = 32'h00000000,
    parameter logic [31:0] BASE_HIGH = 32'hFFF00000
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sc_exec,
    input wire logic [31:0] sc_instr,
    input wire logic [31:0] sc_addr,
    input wire logic float_exc_raise,
    input wire logic [31:0] next_instr_addr,
    output logic resume_valid,
    output logic [31:0] resume_addr,
    output logic [31:0] machine_state_out
);
    typedef struct packed
    {
        logic [31:0] machine_state;
        logic [31:0] save_restore_address;
        logic [31:0] save_restore_status;
        logic [31:0] link_return;
        logic [31:0] loop_count;
        logic [31:0] float_status_control;
        logic [1:0] last_kind;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic resume_valid;
        logic [31:0] resume_addr;
    } ifs_state_s;

    ifs_state_s st_q;
    ifs_state_s st_d;
    ifs_kind_e kind;
    logic imprecise_cond;
    logic bus_write;
    logic bus_setup;
    logic mapped;
    logic [31:0] ms_cur;
    logic [31:0] ms_cleared;

    ifs_vec_if vec ();

    ifs_vector #(
        .BASE_LOW(BASE_LOW),
        .BASE_HIGH(BASE_HIGH)
    ) u_vector (
        .v(vec)
    );

    assign bus_setup = psel && !penable;
    assign bus_write = psel && penable && st_q.ready && pwrite;

    always_comb
    begin
        mapped = 1'b1;
        unique case (paddr)
            IFS_OFS_MACHINE_STATE,
            IFS_OFS_SAVE_RESTORE_ADDRESS,
            IFS_OFS_SAVE_RESTORE_STATUS,
            IFS_OFS_LINK_RETURN,
            IFS_OFS_LOOP_COUNT,
            IFS_OFS_FLOAT_STATUS_CONTROL,
            IFS_OFS_ENTRY_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Software writes land first so an entry in the same cycle overrides them
    always_comb
    begin
        st_d = st_q;
        st_d.ready = bus_setup;
        st_d.slverr = bus_setup && !mapped;
        st_d.resume_valid = 1'b0;
        st_d.rdata = IFS_RESET_WORD;
        if (bus_setup)
        begin
            unique case (paddr)
                IFS_OFS_MACHINE_STATE: st_d.rdata = st_q.machine_state;
                IFS_OFS_SAVE_RESTORE_ADDRESS: st_d.rdata = st_q.save_restore_address;
                IFS_OFS_SAVE_RESTORE_STATUS: st_d.rdata = st_q.save_restore_status;
                IFS_OFS_LINK_RETURN: st_d.rdata = st_q.link_return;
                IFS_OFS_LOOP_COUNT: st_d.rdata = st_q.loop_count;
                IFS_OFS_FLOAT_STATUS_CONTROL: st_d.rdata = st_q.float_status_control;
                IFS_OFS_ENTRY_STATUS: st_d.rdata = {30'h00000000, st_q.last_kind};
                default: st_d.rdata = IFS_RESET_WORD;
            endcase
        end
        if (bus_write)
        begin
            unique case (paddr)
                IFS_OFS_MACHINE_STATE: st_d.machine_state = pwdata;
                IFS_OFS_SAVE_RESTORE_ADDRESS: st_d.save_restore_address = pwdata;
                IFS_OFS_SAVE_RESTORE_STATUS: st_d.save_restore_status = pwdata;
                IFS_OFS_LINK_RETURN: st_d.link_return = pwdata;
                IFS_OFS_LOOP_COUNT: st_d.loop_count = pwdata;
                IFS_OFS_FLOAT_STATUS_CONTROL: st_d.float_status_control = pwdata;
                default: ;
            endcase
        end
        // Hardware raising the summary wins over a software clear
        if (float_exc_raise)
        begin
            st_d.float_status_control[IFS_FSC_FLOAT_EXC_SUMMARY] = 1'b1;
        end
    end

    always_comb
    begin
        ms_cur = st_q.machine_state;
        imprecise_cond = st_q.float_status_control[IFS_FSC_FLOAT_EXC_SUMMARY]
            && !ms_cur[IFS_MS_FLOAT_EXC_MODE]
            && ms_cur[IFS_MS_IMPRECISE_ALLOW];
        // A call outranks a pending imprecise entry, which is taken next cycle
        if (sc_exec)
        begin
            kind = IFS_KIND_SC;
        end
        else if (imprecise_cond)
        begin
            kind = IFS_KIND_IMPRECISE;
        end
        else
        begin
            kind = IFS_KIND_NONE;
        end
        vec.is_sc = (kind == IFS_KIND_SC);
        vec.base_high = ms_cur[IFS_MS_VECTOR_BASE_SELECT];
        vec.absolute = sc_instr[IFS_SC_ABSOLUTE_VECTOR_SELECT];
        vec.entry_index = sc_instr[IFS_SC_ENTRY_INDEX_LSB +: IFS_SC_ENTRY_INDEX_W];
        ms_cleared = ms_cur;
        if (kind == IFS_KIND_IMPRECISE)
        begin
            ms_cleared[IFS_MS_EXTERNAL_IRQ_ENABLE] = 1'b0;
            ms_cleared[IFS_MS_USER_MODE_FLAG] = 1'b0;
            ms_cleared[IFS_MS_FLOAT_AVAILABLE] = 1'b0;
            ms_cleared[IFS_MS_FLOAT_EXC_MODE] = 1'b0;
            ms_cleared[IFS_MS_SINGLE_STEP_TRACE] = 1'b0;
            ms_cleared[IFS_MS_BRANCH_TRACE] = 1'b0;
            ms_cleared[IFS_MS_IMPRECISE_ALLOW] = 1'b0;
            ms_cleared[IFS_MS_WORD_BOUNDARY_CHECK] = 1'b0;
            ms_cleared[IFS_MS_INSTR_TRANSLATE] = 1'b0;
            ms_cleared[IFS_MS_PERF_MONITOR_MARK] = 1'b0;
            ms_cleared[IFS_MS_DATA_TRANSLATE] = 1'b0;
        end
        else if (kind == IFS_KIND_SC)
        begin
            ms_cleared[IFS_MS_EXTERNAL_IRQ_ENABLE] = 1'b0;
            ms_cleared[IFS_MS_USER_MODE_FLAG] = 1'b0;
            ms_cleared[IFS_MS_FLOAT_EXC_MODE] = 1'b0;
        end
    end

    ifs_state_s st_e;

    always_comb
    begin
        st_e = st_d;
        unique case (kind)
            IFS_KIND_IMPRECISE:
            begin
                st_e.save_restore_address = next_instr_addr;
                st_e.save_restore_status = {16'h0000, ms_cur[15:0]};
                st_e.machine_state = ms_cleared;
                st_e.resume_valid = 1'b1;
                st_e.resume_addr = vec.target;
                st_e.last_kind = 2'h1;
            end
            IFS_KIND_SC:
            begin
                if (sc_instr[IFS_SC_SAVE_RETURN_FLAG])
                begin
                    st_e.link_return = sc_addr + IFS_INSTR_BYTES;
                end
                st_e.loop_count = {sc_instr[15:0], ms_cur[15:0]};
                st_e.machine_state = ms_cleared;
                st_e.resume_valid = 1'b1;
                st_e.resume_addr = vec.target;
                st_e.last_kind = 2'h2;
            end
            IFS_KIND_NONE: ;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_e;
        end
    end

    assign prdata = st_q.rdata;
    assign pready = st_q.ready;
    assign pslverr = st_q.slverr;
    assign resume_valid = st_q.resume_valid;
    assign resume_addr = st_q.resume_addr;
    assign machine_state_out = st_q.machine_state;
endmodule

// ==== verif/ifs_entry_chk.sv ====
// Port-level checker for the entry unit
module ifs_entry_chk
    import ifs_pkg::*;
#(
    parameter logic [31:0] BASE_LOW = 32'h00000000,
    parameter logic [31:0] BASE_HIGH = 32'hFFF00000
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic sc_exec,
    input wire logic [31:0] sc_instr,
    input wire logic resume_valid,
    input wire logic [31:0] resume_addr,
    input wire logic [31:0] machine_state_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [31:0] base;
    logic fp_hit;
    logic sc_exec_q;
    assign base = machine_state_out[6] ? BASE_HIGH : BASE_LOW;
    assign fp_hit = resume_valid && !sc_exec_q;
    always_ff @(posedge clk) sc_exec_q <= sc_exec;
    a_pready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    a_pready_one_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_call_takes_entry: assert property (sc_exec |=> resume_valid)
        else $error("call not taken");
    a_call_clears_bits: assert property (sc_exec |=> machine_state_out[15:14] == 2'h0
        && !machine_state_out[11]) else $error("call state not cleared");
    a_call_keeps_bits: assert property (sc_exec
        |=> $stable({machine_state_out[13:12], machine_state_out[7:4]}))
        else $error("call changed kept bits");
    a_call_abs_vector: assert property (sc_exec && sc_instr[1]
        |=> resume_addr == base + IFS_VEC_SC_ABSOLUTE) else $error("absolute vector wrong");
    a_call_index_vector: assert property (sc_exec && !sc_instr[1] |=> resume_addr ==
        base + {15'h0000, 5'h01, $past(sc_instr[11:5]), 5'h00}) else $error("index vector wrong");
    a_fp_clears_bits: assert property (fp_hit
        |-> (machine_state_out & 32'h0000EFB4) == 32'h00000000)
        else $error("imprecise state not cleared");
    a_fp_keeps_bits: assert property (fp_hit
        |-> $stable({machine_state_out[12], machine_state_out[6]}))
        else $error("imprecise changed kept bits");
    a_fp_vector: assert property (fp_hit |-> resume_addr == base + IFS_VEC_IMPRECISE)
        else $error("imprecise vector wrong");
    a_fp_needs_allow: assert property (fp_hit |-> $past(machine_state_out[8]
        && !machine_state_out[11])) else $error("imprecise entry not allowed");
    c_fp_entry: cover property (fp_hit);
    c_call_abs: cover property (sc_exec && sc_instr[1]);
    c_call_index: cover property (sc_exec && !sc_instr[1]);
endmodule

bind ifs_entry ifs_entry_chk #(.BASE_LOW(BASE_LOW), .BASE_HIGH(BASE_HIGH)) u_chk (.clk(clk),
    .reset(reset), .psel(psel), .penable(penable), .pready(pready), .sc_exec(sc_exec),
    .sc_instr(sc_instr), .resume_valid(resume_valid), .resume_addr(resume_addr),
    .machine_state_out(machine_state_out));

// ==== verif/tb_ifs_entry.sv ====
// Testbench for the entry unit
module tb_ifs_entry
    import ifs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, sc_exec = 0, fraise = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, sc_instr = 0, sc_addr = 0, nxt = 32'h00003330;
    logic [31:0] prdata, resume_addr, ms_out, r;
    logic pready, pslverr, resume_valid, e;
    int error_cnt = 0, num_checks = 0;
    ifs_entry dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sc_exec(sc_exec), .sc_instr(sc_instr), .sc_addr(sc_addr), .float_exc_raise(fraise),
        .next_instr_addr(nxt), .resume_valid(resume_valid), .resume_addr(resume_addr),
        .machine_state_out(ms_out));
    initial
    begin
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        chk(n < 20, 1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(0, a, 0);
        chk(r, x);
    endtask
    task automatic call(input logic [31:0] ins, input logic [31:0] x, input logic [31:0] m);
        @(posedge clk);
        sc_exec <= 1;
        sc_instr <= ins;
        sc_addr <= 32'h00002000;
        @(posedge clk);
        sc_exec <= 0;
        @(posedge clk);
        chk(resume_valid, 1);
        chk(resume_addr, x);
        chk(ms_out, m);
    endtask
    task automatic t_reset;
        rd(IFS_OFS_MACHINE_STATE, 0);
        apb(0, 8'h1C, 0);
        chk(e, 1);
        chk(r, 32'h00000000);
    endtask
    task automatic t_call_index;
        apb(1, IFS_OFS_MACHINE_STATE, 32'h0000F8B0);
        call(32'hABCD0AA1, 32'h00001AA0, 32'h000030B0);
        rd(IFS_OFS_LOOP_COUNT, 32'h0AA1F8B0);
        rd(IFS_OFS_LINK_RETURN, 32'h00002004);
    endtask
    task automatic t_call_abs;
        apb(1, IFS_OFS_LINK_RETURN, 32'h12345678);
        apb(1, IFS_OFS_MACHINE_STATE, 32'h00008040);
        call(32'h00000002, 32'hFFF01FE0, 32'h00000040);
        rd(IFS_OFS_LINK_RETURN, 32'h12345678);
        rd(IFS_OFS_LOOP_COUNT, 32'h00028040);
        rd(IFS_OFS_ENTRY_STATUS, 32'h00000002);
    endtask
    task automatic t_imprecise;
        int n;
        n = 0;
        apb(1, IFS_OFS_MACHINE_STATE, 0);
        @(posedge clk);
        fraise <= 1;
        @(posedge clk);
        fraise <= 0;
        repeat (4) @(posedge clk);
        chk(resume_valid, 0);
        apb(1, IFS_OFS_MACHINE_STATE, 32'h00000900);
        repeat (3) @(posedge clk);
        chk(resume_valid, 0);
        chk(ms_out, 32'h00000900);
        apb(1, IFS_OFS_MACHINE_STATE, 32'h0000F7F4);
        while (resume_valid !== 1'b1 && n < 10)
        begin
            @(posedge clk);
            n++;
        end
        chk(resume_valid, 1);
        chk(resume_addr, 32'hFFF00A00);
        chk(ms_out, 32'h00001040);
        rd(IFS_OFS_SAVE_RESTORE_ADDRESS, 32'h00003330);
        rd(IFS_OFS_SAVE_RESTORE_STATUS, 32'h0000F7F4);
        rd(IFS_OFS_FLOAT_STATUS_CONTROL, 32'h40000000);
        rd(IFS_OFS_ENTRY_STATUS, 32'h00000001);
    endtask
    task automatic summarize;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #500000;
        error_cnt++;
        summarize();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 0;
        t_reset();
        t_call_index();
        t_call_abs();
        t_imprecise();
        summarize();
    end
endmodule
